// ===== verilog/hwmul_top.sv
// top: 8x8 multiplier with product register pair and flag pass-through
// ----------------------------------------------------------------
// Overview of operation
// - one 8x8 multiply completes in a single cycle, no iteration.
// - operands are unsigned; the full 16-bit product is kept.
// - upper product byte goes to high register, lower to low register.
// - a multiply leaves every ALU status flag unchanged.
// - multiply takes working register times addressed file register.
// ----------------------------------------------------------------
`default_nettype none
module hwmul_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // instruction decode
   input wire logic mul_en,
   input wire hwmul_pkg::hwmul_byte_t working_register,
   input wire hwmul_pkg::hwmul_byte_t file_operand,
   // product register writes from ordinary moves
   input wire logic prod_high_we,
   input wire logic prod_low_we,
   input wire hwmul_pkg::hwmul_byte_t prod_wdata,
   // alu flag update from other instructions
   input wire logic flag_we,
   input wire hwmul_pkg::hwmul_flag_t flag_wdata,
   // register outputs
   output logic [7:0] product_high_byte,
   output logic [7:0] product_low_byte,
   output logic [4:0] alu_flag_register
);
   import hwmul_pkg::*;
   hwmul_if mif ();
   hwmul_byte_t product_high_byte_q;
   hwmul_byte_t product_low_byte_q;
   hwmul_flag_t flag_q;
   hwmul_prod_t prod_d;

   // ----------------------------------------------------------------
   // operand steering and core
   // ----------------------------------------------------------------
   assign mif.op_a = working_register;
   assign mif.op_b = file_operand;
   hwmul_array u_array (
      .mif(mif.core)
   );
   assign prod_d = mif.product;

   // ----------------------------------------------------------------
   // product register pair
   // ----------------------------------------------------------------
   // multiply wins over a move in the same cycle; decode should never issue both
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         product_high_byte_q <= HWMUL_BYTE_RST;
      end else if (mul_en) begin
         product_high_byte_q <= prod_d[HWMUL_PROD_W-1:HWMUL_OP_W];
      end else if (prod_high_we) begin
         product_high_byte_q <= prod_wdata;
      end
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         product_low_byte_q <= HWMUL_BYTE_RST;
      end else if (mul_en) begin
         product_low_byte_q <= prod_d[HWMUL_OP_W-1:0];
      end else if (prod_low_we) begin
         product_low_byte_q <= prod_wdata;
      end
   end

   // ----------------------------------------------------------------
   // alu flags: multiply never writes them
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flag_q <= HWMUL_FLAG_RST;
      end else if (flag_we && !mul_en) begin
         flag_q <= flag_wdata;
      end
   end

   // registered outputs, visible straight after the writing edge
   assign product_high_byte = product_high_byte_q;
   assign product_low_byte = product_low_byte_q;
   assign alu_flag_register = flag_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_prod_full: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> {product_high_byte_q, product_low_byte_q} == $past(working_register) * $past(file_operand))
      else $error("product pair does not equal full unsigned product");
   a_prod_high: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> product_high_byte_q == 8'(({8'h00, $past(working_register)} * {8'h00, $past(file_operand)}) >> 8))
      else $error("high byte wrong after multiply");
   a_one_cycle: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en ##1 mul_en |=> {product_high_byte_q, product_low_byte_q} == $past(working_register) * $past(file_operand))
      else $error("back to back multiply not single cycle");
   a_flags_kept: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> $stable(alu_flag_register))
      else $error("multiply changed alu flags");
   a_next_read: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> product_low_byte == 8'($past(working_register) * $past(file_operand)))
      else $error("product not visible next cycle");
   a_hold_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      !mul_en && !prod_high_we && !prod_low_we |=> $stable({product_high_byte_q, product_low_byte_q}))
      else $error("product changed without a write");

   a_prod_low: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> product_low_byte_q == 8'($past(working_register) * $past(file_operand)))
      else $error("low byte wrong after multiply");

   a_high_next: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en |=> product_high_byte == 8'(({8'h00, $past(working_register)} * {8'h00, $past(file_operand)}) >> 8))
      else $error("high byte not visible next cycle");

   a_core_comb: assert property (@(posedge core_clk) disable iff (!nrst)
      mif.product == hwmul_prod_t'(working_register) * hwmul_prod_t'(file_operand))
      else $error("array core product wrong in the same cycle");

   a_zero_factor: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en && (working_register == HWMUL_BYTE_RST || file_operand == HWMUL_BYTE_RST)
      |=> {product_high_byte_q, product_low_byte_q} == HWMUL_PROD_RST)
      else $error("zero factor gave a nonzero product");

   a_one_factor: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en && file_operand == 8'h01 |=> product_high_byte_q == HWMUL_BYTE_RST && product_low_byte_q == $past(working_register))
      else $error("unit factor did not pass the other factor");

   a_max_product: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en && working_register == 8'hff && file_operand == 8'hff |=> {product_high_byte_q, product_low_byte_q} == 16'hfe01)
      else $error("largest product truncated");

   // ----------------------------------------------------------------
   // move and flag checks
   // ----------------------------------------------------------------
   a_high_move: assert property (@(posedge core_clk) disable iff (!nrst)
      !mul_en && prod_high_we |=> product_high_byte_q == $past(prod_wdata))
      else $error("high byte move lost");

   a_low_move: assert property (@(posedge core_clk) disable iff (!nrst)
      !mul_en && prod_low_we |=> product_low_byte_q == $past(prod_wdata))
      else $error("low byte move lost");

   a_move_refused: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en && (prod_high_we || prod_low_we)
      |=> {product_high_byte_q, product_low_byte_q} == hwmul_prod_t'($past(working_register)) * hwmul_prod_t'($past(file_operand)))
      else $error("move beat a multiply in the same cycle");

   a_high_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      !mul_en && !prod_high_we |=> $stable(product_high_byte_q))
      else $error("high byte changed without a write");

   a_low_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      !mul_en && !prod_low_we |=> $stable(product_low_byte_q))
      else $error("low byte changed without a write");

   a_flag_write: assert property (@(posedge core_clk) disable iff (!nrst)
      flag_we && !mul_en |=> alu_flag_register == $past(flag_wdata))
      else $error("flag write lost");

   a_flag_hold: assert property (@(posedge core_clk) disable iff (!nrst)
      !flag_we |=> $stable(alu_flag_register))
      else $error("flags changed without a write");

   a_flag_refused: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_en && flag_we |=> $stable(alu_flag_register))
      else $error("flag write taken during a multiply");

   a_reset_clear: assert property (@(posedge core_clk)
      !nrst |-> {product_high_byte_q, product_low_byte_q, flag_q} == '0)
      else $error("registers not cleared in reset");

   // ----------------------------------------------------------------
   // check-only shadow of the pair
   // ----------------------------------------------------------------
   // last value written into the pair, so a long idle stretch is held
   // against it without any unbounded repetition
   hwmul_prod_t last_wr_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         last_wr_q <= HWMUL_PROD_RST;
      end else if (mul_en) begin
         last_wr_q <= hwmul_prod_t'(working_register) * hwmul_prod_t'(file_operand);
      end else begin
         if (prod_high_we) begin
            last_wr_q[HWMUL_PROD_W-1:HWMUL_OP_W] <= prod_wdata;
         end
         if (prod_low_we) begin
            last_wr_q[HWMUL_OP_W-1:0] <= prod_wdata;
         end
      end
   end

   a_pair_stands: assert property (@(posedge core_clk) disable iff (!nrst)
      {product_high_byte, product_low_byte} == last_wr_q)
      else $error("product pair differs from last written value");

   // ----------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------
   c_mul: cover property (@(posedge core_clk) disable iff (!nrst) mul_en);
   c_mul_max: cover property (@(posedge core_clk) disable iff (!nrst)
      mul_en && working_register == 8'hff && file_operand == 8'hff);
   c_back2back: cover property (@(posedge core_clk) disable iff (!nrst) mul_en ##1 mul_en);
   c_move_clash: cover property (@(posedge core_clk) disable iff (!nrst)
      mul_en && (prod_high_we || prod_low_we));
   c_flag_clash: cover property (@(posedge core_clk) disable iff (!nrst) mul_en && flag_we);
endmodule
`default_nettype wire

// ===== verilog/hwmul_pkg.sv
// package: widths and reset values for the 8x8 hardware multiplier
`default_nettype none
package hwmul_pkg;
   localparam int HWMUL_OP_W = 8;
   localparam int HWMUL_PROD_W = 2 * HWMUL_OP_W;
   localparam int HWMUL_FLAG_W = 5;
   localparam logic [HWMUL_OP_W-1:0] HWMUL_BYTE_RST = 8'h00;
   localparam logic [HWMUL_FLAG_W-1:0] HWMUL_FLAG_RST = 5'h00;
   localparam logic [HWMUL_PROD_W-1:0] HWMUL_PROD_RST = 16'h0000;
   typedef logic [HWMUL_OP_W-1:0] hwmul_byte_t;
   typedef logic [HWMUL_PROD_W-1:0] hwmul_prod_t;
   typedef logic [HWMUL_FLAG_W-1:0] hwmul_flag_t;
endpackage
`default_nettype wire

// ===== verilog/hwmul_if.sv
// interface: operand pair and product between top and array core
`default_nettype none
interface hwmul_if;
   import hwmul_pkg::*;
   hwmul_byte_t op_a;
   hwmul_byte_t op_b;
   hwmul_prod_t product;
   modport ctrl (output op_a, output op_b, input product);
   modport core (input op_a, input op_b, output product);
endinterface
`default_nettype wire

// ===== verilog/hwmul_array.sv
// combinational 8x8 unsigned array multiplier core
`default_nettype none
module hwmul_array (
   // operands and product
   hwmul_if.core mif
);
   import hwmul_pkg::*;
   hwmul_prod_t pp [HWMUL_OP_W];
   // one shifted partial product per multiplier bit, summed in one pass
   genvar gi;
   for (gi = 0; gi < HWMUL_OP_W; gi++) begin : g_pp
      assign pp[gi] = mif.op_b[gi] ? (hwmul_prod_t'(mif.op_a) << gi) : HWMUL_PROD_RST;
   end
   always_comb begin
      hwmul_prod_t acc;
      acc = HWMUL_PROD_RST;
      for (int i = 0; i < HWMUL_OP_W; i++) begin
         acc = acc + pp[i];
      end
      mif.product = acc;
   end
endmodule
`default_nettype wire

// ===== test/hwmul_cpu_model.sv
// partner: core decoder issuing one instruction a cycle
`default_nettype none
module hwmul_cpu_model (
   input wire logic core_clk,
   output logic mul_en, prod_high_we, prod_low_we, flag_we,
   output hwmul_pkg::hwmul_byte_t working_register, file_operand, prod_wdata,
   output hwmul_pkg::hwmul_flag_t flag_wdata
);
   timeunit 1ns / 1ps;
   import hwmul_pkg::*;
   initial {mul_en, prod_high_we, prod_low_we, flag_we, working_register, file_operand, prod_wdata, flag_wdata} = '0;
   // driven after one edge and held, so the next edge takes it
   task automatic op(input logic m, fw, input logic [1:0] pw, input hwmul_byte_t a, b, d);
      @(posedge core_clk);
      {mul_en, flag_we, prod_high_we, prod_low_we} <= {m, fw, pw};
      {working_register, file_operand, prod_wdata, flag_wdata} <= {a, b, d, d[4:0]};
   endtask
endmodule
`default_nettype wire

// ===== test/hw_multiplier_8x8_tb.sv
// testbench: multiply, flag and product write checks
`default_nettype none
module hw_multiplier_8x8_tb;
   timeunit 1ns / 1ps;
   import hwmul_pkg::*;
   logic core_clk = 1'b0, nrst = 1'b0, mul_en, prod_high_we, prod_low_we, flag_we;
   hwmul_byte_t working_register, file_operand, prod_wdata, product_high_byte, product_low_byte;
   hwmul_flag_t flag_wdata, alu_flag_register;
   hwmul_byte_t a [5] = '{8'hff, 8'hff, 8'h12, 8'h80, 8'h03};
   int n_mismatch = 0, n_compared = 0;
   wire hwmul_prod_t pr = {product_high_byte, product_low_byte};
   always #2 core_clk = ~core_clk;
   hwmul_cpu_model cpu (.core_clk, .mul_en, .prod_high_we, .prod_low_we, .flag_we, .working_register,
      .file_operand, .prod_wdata, .flag_wdata);
   hwmul_top DUT (.core_clk, .nrst, .mul_en, .working_register, .file_operand, .prod_high_we, .prod_low_we,
      .prod_wdata, .flag_we, .flag_wdata, .product_high_byte, .product_low_byte, .alu_flag_register);
   task automatic check(input string nm, input hwmul_prod_t got, exp);
      n_compared++;
      if (got !== exp) n_mismatch++;
      if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // moves and flag writes in the multiply cycle must lose
   task automatic t_flags();
      check("reset", pr | 16'(alu_flag_register), 16'h0000);
      cpu.op('0, '1, '0, 8'h00, 8'h00, 8'h15);
      cpu.op('1, '1, '1, 8'h0b, 8'h0d, 8'h0a);
      cpu.op('0, '0, 2'b10, 8'h0b, 8'h0d, 8'h5a);
      @(negedge core_clk);
      check("flags", 16'(alu_flag_register), 16'h0015);
      check("refused", pr, 16'h008f);
      cpu.op('0, '0, '0, 8'h0b, 8'h0d, 8'h00);
      @(negedge core_clk);
      check("written", pr, 16'h5a8f);
      $display("t_flags done");
   endtask
   // back to back multiplies, each read in the very next cycle
   task automatic t_mul();
      for (int i = 0; i < 6; i++) begin
         cpu.op(i < 5, '0, '0, a[i % 5], a[(i + 1) % 5], 8'h00);
         @(negedge core_clk);
         if (i > 0) check("product", pr, 16'(a[i - 1]) * 16'(a[i % 5]));
      end
      $display("t_mul done");
   endtask
   // one multiply, then an idle slot so the product is taken and read
   task automatic mul_read(input hwmul_byte_t x, y, output hwmul_prod_t p);
      cpu.op('1, '0, '0, x, y, 8'h00);
      cpu.op('0, '0, '0, x, y, 8'h00);
      @(negedge core_clk);
      p = pr;
   endtask
   // signed 8x8: correct the high byte by the sign of each factor
   task automatic t_signed(input hwmul_byte_t x, y, input hwmul_prod_t exp);
      hwmul_prod_t p;
      hwmul_byte_t h;
      mul_read(x, y, p);
      h = p[15:8] - (x[7] ? y : 8'h00) - (y[7] ? x : 8'h00);
      cpu.op('0, '0, 2'b10, x, y, h);
      cpu.op('0, '0, '0, x, y, 8'h00);
      @(negedge core_clk);
      check("signed", pr, exp);
      $display("t_signed done");
   endtask
   // 16x16 from four partial products summed with carry
   task automatic t_wide(input logic [15:0] x, y, input logic [31:0] exp);
      hwmul_prod_t hh, hl, lh, ll;
      logic [31:0] wide_result_bytes;
      mul_read(x[15:8], y[15:8], hh);
      mul_read(x[15:8], y[7:0], hl);
      mul_read(x[7:0], y[15:8], lh);
      mul_read(x[7:0], y[7:0], ll);
      wide_result_bytes = {hh, 16'h0000} + {8'h00, hl, 8'h00} + {8'h00, lh, 8'h00} + {16'h0000, ll};
      check("wide high", wide_result_bytes[31:16], exp[31:16]);
      check("wide low", wide_result_bytes[15:0], exp[15:0]);
      $display("t_wide done");
   endtask
   // reset in mid-run clears the pair and the flags
   task automatic t_reset();
      @(posedge core_clk);
      nrst <= 1'b0;
      @(negedge core_clk);
      check("mid reset", pr | 16'(alu_flag_register), 16'h0000);
      @(posedge core_clk);
      nrst <= 1'b1;
      $display("t_reset done");
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      t_flags();
      t_mul();
      t_signed(8'hfd, 8'h05, 16'hfff1);
      t_signed(8'hfe, 8'hfd, 16'h0006);
      t_wide(16'h1234, 16'h5678, 32'h0626_0060);
      t_wide(16'hffff, 16'hffff, 32'hfffe_0001);
      t_reset();
      t_mul();
      wrap_up();
   end
   initial begin
      #2000 n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
